// ==== src/upf_pkg.sv ====
// Constants and types shared by the parallel FIFO port design.
`default_nettype none
package upf_pkg;
   localparam int TX_DEPTH = 128;
   localparam int TX_AW    = 7;
   localparam int RX_DEPTH = 256;
   localparam int RX_AW    = 8;
   localparam int SYNC_W   = 12;

   localparam logic [1:0] MODE_FIFO     = 2'h0;
   localparam logic [1:0] MODE_ASYNC_BB = 2'h1;
   localparam logic [1:0] MODE_SYNC_BB  = 2'h2;

   localparam logic [7:0] TIMEOUT_DEF_MS = 8'h10;
   localparam logic [7:0] TIMEOUT_MIN_MS = 8'h02;

   localparam int CLK_PERIOD_NS = 25;
   localparam int MS_NS         = 1000000;
   localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
   localparam int WAKE_MIN_MS   = 20;
   localparam int WAKE_CYCLES   =
      (WAKE_MIN_MS * MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam logic [SYNC_W-1:0] SYNC_RST = 12'hf00;
   localparam logic [31:0]       CHIP_ID_DEF = 32'h5a5a_0001;

   typedef enum logic [2:0] {
      RD_IDLE  = 3'b001,
      RD_FETCH = 3'b010,
      RD_DRIVE = 3'b100
   } rd_state_e;
endpackage
`default_nettype wire

// ==== src/mem_if.sv ====
// Write and read port bundle of one byte buffer.
`timescale 1ns/1ps
`default_nettype none
interface mem_if #(parameter int AW = 8);
   logic          we;
   logic [AW-1:0] waddr;
   logic [7:0]    wdata;
   logic          re;
   logic [AW-1:0] raddr;
   logic [7:0]    rdata;
   modport ctrl (output we, waddr, wdata, re, raddr, input rdata);
   modport mem  (input we, waddr, wdata, re, raddr, output rdata);
endinterface
`default_nettype wire

// ==== src/byte_mem.sv ====
// Byte buffer memory with registered read data.
`timescale 1ns/1ps
`default_nettype none
module byte_mem #(parameter int AW = 8) (
   input  wire logic clk_in,
   mem_if.mem        port_if
);
   logic [7:0] mem_ff [2**AW];

   always_ff @(posedge clk_in) begin
      if (port_if.we) begin
         mem_ff[port_if.waddr] <= port_if.wdata;
      end
   end

   always_ff @(posedge clk_in) begin
      if (port_if.re) begin
         port_if.rdata <= mem_ff[port_if.raddr];
      end
   end
endmodule
`default_nettype wire

// ==== src/pin_sync.sv ====
// Two flip-flop synchroniser for pin inputs.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int             W   = 12,
   parameter logic [W-1:0]   RST = '0
) (
   input  wire logic         clk_in,
   input  wire logic         reset_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] stage1_ff;

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         stage1_ff <= RST;
         q_out     <= RST;
      end else begin
         stage1_ff <= d_in;
         q_out     <= stage1_ff;
      end
   end
endmodule
`default_nettype wire

// ==== src/usb_parallel_fifo_port.sv ====
// Device-side controller between the USB function and the parallel port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Async bit-bang turns the eight data lines into a general I/O port.
// - Async bit-bang presents host bytes one by one at baud timer pace.
// - Bit-bang drives the internal read and write strobes onto the pins.
// - Sync bit-bang samples the pins only when a byte is written out.
// - Timeout expiry flushes bytes left in the port-to-host buffer.
// - Flush timeout defaults to 16 ms, settable 2 to 255 ms.
// - Suspend with remote wake makes the receive flag pin an input.
// - Receive flag held low 20 ms in suspend raises a resume request.
// - Host bytes queue in 128 bytes and leave on read strobes.
// - Write-strobed port bytes queue in 256 bytes for the host.
// - Port-to-host bytes leave only on a host IN data request.
// - The controller moves both buffers over the shared data pins.
// - Controller and protocol logic run on the one reference clock.
// - The baud timer pacing bit-bang counts reference clock cycles.
// - The active-low external reset pin resets the device.
// - A fixed identification number is readable only toward USB.
// - Receive flag low while host data waits; reads only then.
// - Read strobe falling fetches the next byte and drives it.
// - Write strobe falling captures the data pins into the buffer.
module usb_parallel_fifo_port #(
   parameter int          MS_CYCLES   = upf_pkg::MS_CYCLES,
   parameter int          WAKE_CYCLES = upf_pkg::WAKE_CYCLES,
   parameter logic [31:0] CHIP_ID     = upf_pkg::CHIP_ID_DEF
) (
   input  wire logic       clk_in,
   input  wire logic       reset_in,
   input  wire logic       ext_reset_n_in,
   input  wire logic [1:0] mode_in,
   input  wire logic [15:0] baud_div_in,
   input  wire logic [7:0] bb_dir_in,
   input  wire logic       suspend_in,
   input  wire logic       remote_wake_en_in,
   input  wire logic       timeout_set_in,
   input  wire logic [7:0] timeout_ms_in,
   input  wire logic       host_out_valid_in,
   input  wire logic [7:0] host_out_data_in,
   output logic            host_out_ready_out,
   input  wire logic       host_in_req_in,
   output logic            host_in_valid_out,
   output logic [7:0]      host_in_data_out,
   output logic            host_in_nak_out,
   output logic            flush_out,
   output logic            resume_req_out,
   output logic [31:0]     chip_id_out,
   input  wire logic [7:0] data_pins_in,
   output logic [7:0]      data_pins_out,
   output logic [7:0]      data_pins_oe_out,
   input  wire logic       rd_strobe_n_in,
   output logic            rd_strobe_n_out,
   output logic            rd_strobe_oe_out,
   input  wire logic       wr_strobe_in,
   output logic            wr_strobe_out,
   output logic            wr_strobe_oe_out,
   input  wire logic       rx_avail_flag_n_in,
   output logic            rx_avail_flag_n_out,
   output logic            rx_avail_flag_oe_out,
   output logic            tx_space_flag_n_out,
   output logic            tx_space_flag_oe_out
);
   logic [upf_pkg::SYNC_W-1:0] sync_q;
   logic                       rst;
   logic [7:0]                 pins_s;
   logic                       rd_n_s;
   logic                       wr_s;
   logic                       rx_flag_s;
   logic                       rd_prev_ff;
   logic                       wr_prev_ff;
   logic                       rd_fall;
   logic                       wr_fall;
   logic                       is_fifo;
   logic                       is_bb;
   logic                       is_sync_bb;
   logic                       wake_armed;
   logic [upf_pkg::TX_AW-1:0]  tx_wptr_ff;
   logic [upf_pkg::TX_AW-1:0]  tx_rptr_ff;
   logic [upf_pkg::TX_AW:0]    tx_count_ff;
   logic [upf_pkg::TX_AW:0]    nxt_tx_count;
   logic                       tx_push;
   logic                       tx_pop;
   logic                       tx_pop_d1_ff;
   logic [upf_pkg::RX_AW-1:0]  rx_wptr_ff;
   logic [upf_pkg::RX_AW-1:0]  rx_rptr_ff;
   logic [upf_pkg::RX_AW:0]    rx_count_ff;
   logic [upf_pkg::RX_AW:0]    nxt_rx_count;
   logic                       rx_push;
   logic                       rx_pop;
   logic                       rx_pop_d1_ff;
   logic                       rx_full_ff;
   logic                       wr_take;
   logic                       bb_sample;
   upf_pkg::rd_state_e         rd_state_ff;
   logic [15:0]                baud_cnt_ff;
   logic                       bb_tick_ff;
   logic [7:0]                 timeout_ms_ff;
   logic [7:0]                 ms_left_ff;
   logic [15:0]                ms_pre_ff;
   logic [19:0]                wake_cnt_ff;

   mem_if #(.AW(upf_pkg::TX_AW)) tx_mem ();
   mem_if #(.AW(upf_pkg::RX_AW)) rx_mem ();

   pin_sync #(.W(upf_pkg::SYNC_W), .RST(upf_pkg::SYNC_RST)) u_sync (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .d_in     ({ext_reset_n_in, rx_avail_flag_n_in, wr_strobe_in,
                  rd_strobe_n_in, data_pins_in}),
      .q_out    (sync_q)
   );

   byte_mem #(.AW(upf_pkg::TX_AW)) u_tx_mem (
      .clk_in  (clk_in),
      .port_if (tx_mem.mem)
   );

   byte_mem #(.AW(upf_pkg::RX_AW)) u_rx_mem (
      .clk_in  (clk_in),
      .port_if (rx_mem.mem)
   );

   assign rst        = reset_in | ~sync_q[11];
   assign rx_flag_s  = sync_q[10];
   assign wr_s       = sync_q[9];
   assign rd_n_s     = sync_q[8];
   assign pins_s     = sync_q[7:0];
   assign is_fifo    = (mode_in == upf_pkg::MODE_FIFO);
   assign is_sync_bb = (mode_in == upf_pkg::MODE_SYNC_BB);
   assign is_bb      = (mode_in == upf_pkg::MODE_ASYNC_BB) | is_sync_bb;
   assign wake_armed = suspend_in & remote_wake_en_in;
   assign rd_fall    = rd_prev_ff & ~rd_n_s;
   assign wr_fall    = wr_prev_ff & ~wr_s;

   always_ff @(posedge clk_in) begin
      if (rst) begin
         rd_prev_ff <= 1'b1;
         wr_prev_ff <= 1'b1;
      end else begin
         rd_prev_ff <= rd_n_s;
         wr_prev_ff <= wr_s;
      end
   end

   // Host to port buffer.
   assign tx_push = host_out_valid_in & host_out_ready_out;
   assign tx_pop  = (tx_count_ff != '0) &
                    ((is_fifo & rd_fall & (rd_state_ff == upf_pkg::RD_IDLE))
                     | (is_bb & bb_tick_ff & (is_fifo | ~is_sync_bb
                        | ~rx_full_ff)));
   assign nxt_tx_count = tx_count_ff + {{upf_pkg::TX_AW{1'b0}}, tx_push}
                         - {{upf_pkg::TX_AW{1'b0}}, tx_pop};
   assign tx_mem.we    = tx_push;
   assign tx_mem.waddr = tx_wptr_ff;
   assign tx_mem.wdata = host_out_data_in;
   assign tx_mem.re    = tx_pop;
   assign tx_mem.raddr = tx_rptr_ff;

   always_ff @(posedge clk_in) begin
      if (rst) begin
         tx_wptr_ff         <= '0;
         tx_rptr_ff         <= '0;
         tx_count_ff        <= '0;
         tx_pop_d1_ff       <= 1'b0;
         host_out_ready_out <= 1'b0;
      end else begin
         tx_wptr_ff         <= tx_wptr_ff + (upf_pkg::TX_AW)'(tx_push);
         tx_rptr_ff         <= tx_rptr_ff + (upf_pkg::TX_AW)'(tx_pop);
         tx_count_ff        <= nxt_tx_count;
         tx_pop_d1_ff       <= tx_pop;
         host_out_ready_out <= ~nxt_tx_count[upf_pkg::TX_AW];
      end
   end

   // Port to host buffer; fifo writes and bit-bang samples share one order.
   assign wr_take   = is_fifo & wr_fall & ~rx_full_ff;
   assign bb_sample = is_sync_bb & tx_pop;
   assign rx_push   = wr_take | bb_sample;
   assign rx_pop    = host_in_req_in & (rx_count_ff != '0);
   assign nxt_rx_count = rx_count_ff + {{upf_pkg::RX_AW{1'b0}}, rx_push}
                         - {{upf_pkg::RX_AW{1'b0}}, rx_pop};
   assign rx_mem.we    = rx_push;
   assign rx_mem.waddr = rx_wptr_ff;
   assign rx_mem.wdata = pins_s;
   assign rx_mem.re    = rx_pop;
   assign rx_mem.raddr = rx_rptr_ff;

   always_ff @(posedge clk_in) begin
      if (rst) begin
         rx_wptr_ff   <= '0;
         rx_rptr_ff   <= '0;
         rx_count_ff  <= '0;
         rx_full_ff   <= 1'b0;
         rx_pop_d1_ff <= 1'b0;
      end else begin
         rx_wptr_ff   <= rx_wptr_ff + (upf_pkg::RX_AW)'(rx_push);
         rx_rptr_ff   <= rx_rptr_ff + (upf_pkg::RX_AW)'(rx_pop);
         rx_count_ff  <= nxt_rx_count;
         rx_full_ff   <= nxt_rx_count[upf_pkg::RX_AW];
         rx_pop_d1_ff <= rx_pop;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst) begin
         host_in_valid_out <= 1'b0;
         host_in_data_out  <= 8'h00;
         host_in_nak_out   <= 1'b0;
      end else begin
         host_in_valid_out <= rx_pop_d1_ff;
         host_in_nak_out   <= host_in_req_in & (rx_count_ff == '0);
         if (rx_pop_d1_ff) begin
            host_in_data_out <= rx_mem.rdata;
         end
      end
   end

   // Read cycle of the handshaked fifo port.
   always_ff @(posedge clk_in) begin
      if (rst) begin
         rd_state_ff <= upf_pkg::RD_IDLE;
      end else begin
         case (rd_state_ff)
            upf_pkg::RD_IDLE: begin
               if (tx_pop & is_fifo) begin
                  rd_state_ff <= upf_pkg::RD_FETCH;
               end
            end
            upf_pkg::RD_FETCH: begin
               rd_state_ff <= upf_pkg::RD_DRIVE;
            end
            upf_pkg::RD_DRIVE: begin
               if (rd_n_s | ~is_fifo) begin
                  rd_state_ff <= upf_pkg::RD_IDLE;
               end
            end
            default: begin
               rd_state_ff <= upf_pkg::RD_IDLE;
            end
         endcase
      end
   end

   // Data pins serve both buffers and the bit-bang port.
   always_ff @(posedge clk_in) begin
      if (rst) begin
         data_pins_out    <= 8'h00;
         data_pins_oe_out <= 8'h00;
      end else begin
         if (tx_pop_d1_ff) begin
            data_pins_out <= tx_mem.rdata;
         end
         if (is_bb) begin
            data_pins_oe_out <= bb_dir_in;
         end else if (rd_state_ff == upf_pkg::RD_FETCH) begin
            data_pins_oe_out <= 8'hff;
         end else if (rd_state_ff == upf_pkg::RD_IDLE) begin
            data_pins_oe_out <= 8'h00;
         end
      end
   end

   // Strobes become outputs in bit-bang modes.
   always_ff @(posedge clk_in) begin
      if (rst) begin
         rd_strobe_n_out  <= 1'b1;
         rd_strobe_oe_out <= 1'b0;
         wr_strobe_out    <= 1'b1;
         wr_strobe_oe_out <= 1'b0;
      end else begin
         rd_strobe_oe_out <= is_bb;
         wr_strobe_oe_out <= is_bb;
         rd_strobe_n_out  <= ~(is_bb & tx_pop);
         wr_strobe_out    <= ~(is_bb & tx_pop_d1_ff);
      end
   end

   // Handshake flags.
   always_ff @(posedge clk_in) begin
      if (rst) begin
         rx_avail_flag_n_out  <= 1'b1;
         rx_avail_flag_oe_out <= 1'b0;
         tx_space_flag_n_out  <= 1'b1;
         tx_space_flag_oe_out <= 1'b0;
      end else begin
         rx_avail_flag_n_out  <= (nxt_tx_count == '0) | ~is_fifo
                                 | (rd_state_ff != upf_pkg::RD_IDLE)
                                 | tx_pop;
         rx_avail_flag_oe_out <= ~wake_armed;
         tx_space_flag_n_out  <= nxt_rx_count[upf_pkg::RX_AW] | ~is_fifo
                                 | wr_fall;
         tx_space_flag_oe_out <= 1'b1;
      end
   end

   // Bit-bang pacing timer.
   always_ff @(posedge clk_in) begin
      if (rst || !is_bb) begin
         baud_cnt_ff <= 16'h0000;
         bb_tick_ff  <= 1'b0;
      end else if (baud_cnt_ff >= baud_div_in) begin
         baud_cnt_ff <= 16'h0000;
         bb_tick_ff  <= 1'b1;
      end else begin
         baud_cnt_ff <= baud_cnt_ff + 16'h0001;
         bb_tick_ff  <= 1'b0;
      end
   end

   // Flush timeout setting.
   always_ff @(posedge clk_in) begin
      if (rst) begin
         timeout_ms_ff <= upf_pkg::TIMEOUT_DEF_MS;
      end else if (timeout_set_in) begin
         timeout_ms_ff <= (timeout_ms_in < upf_pkg::TIMEOUT_MIN_MS) ?
                          upf_pkg::TIMEOUT_MIN_MS : timeout_ms_in;
      end
   end

   // Flush countdown in whole milliseconds.
   always_ff @(posedge clk_in) begin
      if (rst) begin
         ms_pre_ff  <= 16'h0000;
         ms_left_ff <= upf_pkg::TIMEOUT_DEF_MS;
         flush_out  <= 1'b0;
      end else begin
         flush_out <= 1'b0;
         if (rx_push) begin
            ms_pre_ff  <= 16'h0000;
            ms_left_ff <= timeout_ms_ff;
         end else if (ms_pre_ff == 16'(MS_CYCLES - 1)) begin
            ms_pre_ff <= 16'h0000;
            if (ms_left_ff <= 8'h01) begin
               ms_left_ff <= timeout_ms_ff;
               flush_out  <= (rx_count_ff != '0);
            end else begin
               ms_left_ff <= ms_left_ff - 8'h01;
            end
         end else begin
            ms_pre_ff <= ms_pre_ff + 16'h0001;
         end
      end
   end

   // Remote wake detection on the receive flag pin.
   always_ff @(posedge clk_in) begin
      if (rst || !wake_armed || rx_flag_s) begin
         wake_cnt_ff    <= 20'h00000;
         resume_req_out <= 1'b0;
      end else begin
         if (wake_cnt_ff != 20'(WAKE_CYCLES)) begin
            wake_cnt_ff <= wake_cnt_ff + 20'h00001;
         end
         resume_req_out <= (wake_cnt_ff == 20'(WAKE_CYCLES - 1));
      end
   end

   // Fixed identification number for the USB side.
   always_ff @(posedge clk_in) begin
      chip_id_out <= CHIP_ID;
   end
endmodule
`default_nettype wire

// ==== sim/usb_parallel_fifo_port_chk.sv ====
// Concurrent checks on the ports of the parallel FIFO port controller.
`timescale 1ns/1ps
`default_nettype none
module usb_parallel_fifo_port_chk #(
   parameter int WAKE_CYCLES = 50
) (
   input wire logic       clk_in,
   input wire logic       reset_in,
   input wire logic [1:0] mode_in,
   input wire logic [7:0] bb_dir_in,
   input wire logic       suspend_in,
   input wire logic       remote_wake_en_in,
   input wire logic       host_in_req_in,
   input wire logic       host_in_valid_out,
   input wire logic       host_in_nak_out,
   input wire logic       flush_out,
   input wire logic       resume_req_out,
   input wire logic [7:0] data_pins_oe_out,
   input wire logic       rd_strobe_n_in,
   input wire logic       rd_strobe_oe_out,
   input wire logic       wr_strobe_in,
   input wire logic       wr_strobe_out,
   input wire logic       wr_strobe_oe_out,
   input wire logic       rx_avail_flag_n_in,
   input wire logic       rx_avail_flag_oe_out,
   input wire logic       tx_space_flag_n_out
);
   logic [31:0] low_cnt_ff;
   logic        fifo;

   // Counts cycles of the receive flag pin held low in suspend.
   always_ff @(posedge clk_in) begin
      if (reset_in || rx_avail_flag_n_in || !suspend_in) begin
         low_cnt_ff <= 32'h0;
      end else begin
         low_cnt_ff <= low_cnt_ff + 32'h1;
      end
   end
   assign fifo = (mode_in == upf_pkg::MODE_FIFO);

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (reset_in);

   AST_NAK_REQ: assert property (host_in_nak_out |-> $past(host_in_req_in))
      else $error("nak without request");
   AST_VALID_REQ: assert property (
      host_in_valid_out |-> $past(host_in_req_in, 2))
      else $error("host byte without request");
   AST_FLUSH_GAP: assert property (flush_out |=> !flush_out [*8])
      else $error("flush pulses too close");
   AST_WAKE_INPUT: assert property (
      (suspend_in && remote_wake_en_in) |=> !rx_avail_flag_oe_out)
      else $error("receive flag driven in suspend");
   AST_RD_DRIVE: assert property (
      (fifo && $rose(data_pins_oe_out == 8'hff)) |->
         $past(rd_strobe_n_in, 2) == 1'b0)
      else $error("data driven without read strobe");
   AST_RD_RELEASE: assert property (
      (fifo && $rose(rd_strobe_n_in)) |-> ##[1:6] data_pins_oe_out == 8'h00)
      else $error("data pins not released");
   AST_STROBE_OUT: assert property (
      (!fifo) [*4] |-> rd_strobe_oe_out && wr_strobe_oe_out)
      else $error("strobes not driven in bit-bang");
   AST_BB_DIR: assert property (
      (!fifo && $stable(bb_dir_in)) [*4] |-> data_pins_oe_out == bb_dir_in)
      else $error("bit-bang direction wrong");
   AST_WR_PULSE: assert property ($fell(wr_strobe_out) |=> wr_strobe_out)
      else $error("write strobe pulse too long");
   AST_SPACE_WR: assert property (
      (fifo && $fell(wr_strobe_in)) |-> ##[2:4] tx_space_flag_n_out)
      else $error("space flag not raised after write");
   AST_RESUME: assert property (
      resume_req_out |-> low_cnt_ff >= WAKE_CYCLES)
      else $error("resume after short strobe");
endmodule

bind usb_parallel_fifo_port usb_parallel_fifo_port_chk #(
   .WAKE_CYCLES(WAKE_CYCLES)
) i_usb_parallel_fifo_port_chk (.*);
`default_nettype wire

// ==== sim/ext_logic_model.sv ====
// Behavioural model of the external logic on the parallel port.
`timescale 1ns/1ps
`default_nettype none
module ext_logic_model (
   input  wire logic       clk_in,
   input  wire logic [7:0] dev_data_in,
   input  wire logic [7:0] dev_oe_in,
   input  wire logic       rx_flag_n_in,
   input  wire logic       rx_flag_oe_in,
   input  wire logic       tx_flag_n_in,
   output logic      [7:0] pins_out,
   output logic            rd_n_out,
   output logic            wr_out,
   output logic            rx_pin_out
);
   logic [7:0] drv_val;
   logic       drv_en;
   logic       wake_n;

   initial {drv_val, drv_en, wake_n, rd_n_out, wr_out} = 12'h007;
   // Lines nobody drives float up through the pull-ups.
   assign pins_out = (dev_oe_in & dev_data_in)
                     | (~dev_oe_in & (drv_en ? drv_val : 8'hff));
   assign rx_pin_out = rx_flag_oe_in ? rx_flag_n_in : wake_n;

   task automatic rd_byte(output logic [7:0] b, output logic ok);
      int n;
      n = 0;
      while (rx_flag_n_in !== 1'b0 && n < 200) begin
         @(negedge clk_in);
         n++;
      end
      rd_n_out = 1'b0;
      n = 0;
      while (dev_oe_in !== 8'hff && n < 20) begin
         @(negedge clk_in);
         n++;
      end
      ok = (n < 20);
      b = pins_out;
      @(negedge clk_in);
      rd_n_out = 1'b1;
      repeat (6) @(negedge clk_in);
   endtask

   task automatic wr_byte(input logic [7:0] v, output logic ok);
      int n;
      n = 0;
      while (tx_flag_n_in !== 1'b0 && n < 40) begin
         @(negedge clk_in);
         n++;
      end
      ok = (n < 40);
      if (ok) begin
         drv_val = v;
         drv_en = 1'b1;
         repeat (2) @(negedge clk_in);
         wr_out = 1'b0;
         repeat (4) @(negedge clk_in);
         wr_out = 1'b1;
         @(negedge clk_in);
         drv_en = 1'b0;
         @(negedge clk_in);
      end
   endtask

   task automatic wake(input int cyc);
      wake_n = 1'b0;
      repeat (cyc) @(negedge clk_in);
      wake_n = 1'b1;
   endtask
endmodule
`default_nettype wire

// ==== sim/usb_parallel_fifo_port_tb_top.sv ====
// Self-checking testbench of the parallel FIFO port controller.
`timescale 1ns/1ps
`default_nettype none
module usb_parallel_fifo_port_tb_top;
   localparam int MS = 20;
   localparam int WK = 50;
   localparam logic [31:0] ID = 32'h1234_abcd; // Arbitrary value.
   logic clk_in, reset_in, ext_reset_n_in, suspend_in, remote_wake_en_in;
   logic timeout_set_in, host_out_valid_in, host_in_req_in, flush_out;
   logic host_out_ready_out, host_in_valid_out, host_in_nak_out, nk, ok;
   logic resume_req_out, rd_strobe_n_in, rd_strobe_n_out, rd_strobe_oe_out;
   logic wr_strobe_in, wr_strobe_out, wr_strobe_oe_out, m_rd, m_wr;
   logic rx_avail_flag_n_in, rx_avail_flag_n_out, rx_avail_flag_oe_out;
   logic tx_space_flag_n_out, tx_space_flag_oe_out;
   logic [1:0]  mode_in;
   logic [7:0]  bb_dir_in, timeout_ms_in, host_out_data_in, b;
   logic [7:0]  host_in_data_out, data_pins_in, data_pins_out;
   logic [7:0]  data_pins_oe_out, q[$];
   logic [15:0] baud_div_in;
   logic [31:0] chip_id_out;
   int n_errors, total_checks, n, m, i, c, last, n_res;
   int tv[5] = '{0, 0, 2, 5, 255};
   int tg[5] = '{16, 2, 2, 5, 255};

   usb_parallel_fifo_port #(.MS_CYCLES(MS), .WAKE_CYCLES(WK), .CHIP_ID(ID))
      i_usb_parallel_fifo_port (.*);
   ext_logic_model i_ext_logic_model (.clk_in, .dev_data_in(data_pins_out),
      .dev_oe_in(data_pins_oe_out), .rx_flag_n_in(rx_avail_flag_n_out),
      .rx_flag_oe_in(rx_avail_flag_oe_out), .tx_flag_n_in(tx_space_flag_n_out),
      .pins_out(data_pins_in), .rd_n_out(m_rd), .wr_out(m_wr),
      .rx_pin_out(rx_avail_flag_n_in));
   assign rd_strobe_n_in = rd_strobe_oe_out ? rd_strobe_n_out : m_rd;
   assign wr_strobe_in = wr_strobe_oe_out ? wr_strobe_out : m_wr;

   task automatic check(input string what, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up();
      if (n_errors == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic host_get(output logic [7:0] d, output logic v, k);
      host_in_req_in = 1'b1;
      @(negedge clk_in);
      host_in_req_in = 1'b0;
      k = host_in_nak_out;
      @(negedge clk_in);
      v = host_in_valid_out;
      d = host_in_data_out;
   endtask
   task automatic push(input logic [31:0] w, input int cnt);
      host_out_valid_in = 1'b1;
      for (int j = 0; j < cnt; j++) begin
         host_out_data_in = w[8*j+:8];
         @(negedge clk_in);
      end
      host_out_valid_in = 1'b0;
   endtask
   task automatic wait_flush(output int g);
      g = 0;
      do begin
         @(negedge clk_in);
         g++;
      end while (flush_out !== 1'b1 && g < 12000);
   endtask

   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end
   always @(negedge clk_in) if (resume_req_out === 1'b1) n_res++;
   initial begin
      repeat (80000) @(posedge clk_in);
      n_errors++;
      wrap_up();
   end

   initial begin
      {reset_in, ext_reset_n_in, remote_wake_en_in} = 3'b111;
      {suspend_in, timeout_set_in, host_out_valid_in, host_in_req_in} = 4'h0;
      {mode_in, baud_div_in, bb_dir_in} = {upf_pkg::MODE_FIFO, 16'h3, 8'h3c};
      {timeout_ms_in, host_out_data_in} = 16'h1000;
      {n_errors, total_checks, n_res} = 0;
      repeat (20) @(negedge clk_in);
      check("oe in reset", data_pins_oe_out, 8'h00);
      check("ready in reset", host_out_ready_out, 1'b0);
      reset_in = 1'b0;
      repeat (3) @(negedge clk_in);
      check("rx flag", {rx_avail_flag_oe_out, rx_avail_flag_n_out}, 2'b11);
      check("tx flag", {tx_space_flag_oe_out, tx_space_flag_n_out}, 2'b10);
      check("chip id", chip_id_out, ID);
      n = 0;
      host_out_valid_in = 1'b1;
      while (host_out_ready_out === 1'b1 && n < 200) begin
         host_out_data_in = 8'(n * 3 + 1);
         @(negedge clk_in);
         n++;
      end
      host_out_valid_in = 1'b0;
      check("out taken", n, 128);
      for (i = 0; i < 128; i++) begin
         i_ext_logic_model.rd_byte(b, ok);
         check("port read", {ok, b}, {1'b1, 8'(i * 3 + 1)});
      end
      check("rx flag empty", rx_avail_flag_n_out, 1'b1);
      i_ext_logic_model.rd_byte(b, ok);
      check("read refused", ok, 1'b0);
      n = 0;
      do begin
         i_ext_logic_model.wr_byte(8'(n), ok);
         n += int'(ok);
      end while (ok && n < 300);
      check("in taken", n, 256);
      for (i = 0; i < 5; i++) begin
         if (i > 0) begin
            timeout_ms_in = 8'(tv[i]);
            timeout_set_in = 1'b1;
            @(negedge clk_in);
            timeout_set_in = 1'b0;
         end
         wait_flush(n);
         wait_flush(n);
         check("flush gap", n >= tg[i] * MS - 1 && n <= tg[i] * MS + 1, 1);
      end
      for (i = 0; i < 256; i++) begin
         host_get(b, ok, nk);
         check("in byte", {ok, nk, b}, {2'b10, 8'(i)});
      end
      host_get(b, ok, nk);
      check("in empty", {ok, nk}, 2'b01);
      push(32'h00332211, 3);
      mode_in = upf_pkg::MODE_ASYNC_BB;
      m = 0;
      for (c = 0; c < 80; c++) begin
         @(negedge clk_in);
         if (rd_strobe_n_out === 1'b0) m++;
         if (wr_strobe_out === 1'b0) begin
            if (q.size() > 0) check("bb pace", c - last, 4);
            q.push_back(data_pins_out);
            last = c;
         end
      end
      check("bb oe", data_pins_oe_out, 8'h3c);
      check("bb rd pulses", m, 3);
      check("bb count", q.size(), 3);
      for (i = 0; i < q.size(); i++) check("bb byte", q[i], 8'h11 * (i + 1));
      mode_in = upf_pkg::MODE_FIFO;
      bb_dir_in = 8'h0f;
      i_ext_logic_model.drv_val = 8'ha0;
      i_ext_logic_model.drv_en = 1'b1;
      push(32'h03020105, 4);
      mode_in = upf_pkg::MODE_SYNC_BB;
      repeat (60) @(negedge clk_in);
      for (i = 0; i < 5; i++) begin
         host_get(b, ok, nk);
         q.push_back(b);
      end
      check("sync samples", {q[4], q[5], q[6]}, 24'ha5a1a2);
      check("sync only on write", nk, 1'b1);
      i_ext_logic_model.drv_en = 1'b0;
      mode_in = upf_pkg::MODE_FIFO;
      suspend_in = 1'b1;
      repeat (3) @(negedge clk_in);
      check("flag input", rx_avail_flag_oe_out, 1'b0);
      i_ext_logic_model.wake(WK - 10);
      repeat (20) @(negedge clk_in);
      check("short wake", n_res, 0);
      i_ext_logic_model.wake(WK + 10);
      repeat (20) @(negedge clk_in);
      check("wake", n_res, 1);
      remote_wake_en_in = 1'b0;
      repeat (3) @(negedge clk_in);
      check("flag output", rx_avail_flag_oe_out, 1'b1);
      suspend_in = 1'b0;
      ext_reset_n_in = 1'b0;
      repeat (4) @(negedge clk_in);
      check("ext reset", {host_out_ready_out, tx_space_flag_oe_out}, 2'b00);
      ext_reset_n_in = 1'b1;
      repeat (4) @(negedge clk_in);
      check("ext reset end", host_out_ready_out, 1'b1);
      wrap_up();
   end
endmodule
`default_nettype wire
